// ==== bench/banked_data_memory_indirect_addr_tb.sv ====
// Self-checking bench for the banked data-memory decoder.
// Assumes the core model drives requests 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none

module banked_data_memory_indirect_addr_tb;
  logic                 clk;
  logic                 rst;
  dmem_pkg::file_req_t  file_req;
  dmem_pkg::file_resp_t file_resp;
  logic [7:0]           indirect_pointer;
  logic [7:0]           core_status;
  dmem_pkg::file_resp_t r;
  int                   miscompares;
  int                   compares;
  logic [7:0]           sfr [22] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h0B,
    8'h0C, 8'h1F, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h8A, 8'h8B, 8'h8C, 8'h8E,
    8'h90, 8'h9F};
  logic [7:0]           gaps [5] = '{8'h07, 8'h10, 8'h8D, 8'hA0, 8'hEF};

  initial clk = 1'b0;
  always #50 clk = ~clk;

  core_model u_core (.clk(clk), .file_req(file_req), .file_resp(file_resp));
  banked_data_memory_indirect_addr u_dut (.clk(clk), .rst(rst), .file_req(file_req),
    .file_resp(file_resp), .indirect_pointer(indirect_pointer), .core_status(core_status));

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // A write answers with no valid, zero data and the expected no-storage flag; a read with data one edge on.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic hit);
    u_core.access(1'b0, 1'b1, a, d, r);
    check($sformatf("write %h", a), r, {1'b0, hit, 8'h00});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    u_core.access(1'b1, 1'b0, a, 8'h00, r);
    check($sformatf("read %h", a), r, {1'b1, hit, exp});
  endtask

  // Shared registers keep the bank 1 write, which lands last in the loop.
  function automatic logic [7:0] reg_val(input logic [7:0] a);
    if (a[6:0] inside {7'h02, 7'h03, 7'h04, 7'h0A, 7'h0B})
      return {1'b1, a[6:0]} ^ 8'h5A;
    return a ^ 8'h5A;
  endfunction

  task automatic s_regs();
    foreach (sfr[i]) rd(sfr[i], 8'h00, 1'b0);
    foreach (sfr[i]) wr(sfr[i], sfr[i] ^ 8'h5A, 1'b0);
    foreach (sfr[i]) rd(sfr[i], reg_val(sfr[i]), 1'b0);
    check("pointer", {2'b00, indirect_pointer}, {2'b00, 8'hDE});
  endtask

  task automatic s_gaps();
    foreach (gaps[i]) wr(gaps[i], 8'hFF, 1'b1);
    foreach (gaps[i]) rd(gaps[i], 8'h00, 1'b1);
    wr(8'h70, 8'h11, 1'b0);
    rd(8'hF0, 8'h11, 1'b0);
    wr(8'hFF, 8'h22, 1'b0);
    rd(8'h7F, 8'h22, 1'b0);
    // Read and write in one access: the read must show the byte from before the write.
    u_core.access(1'b1, 1'b1, 8'hF0, 8'h33, r);
    check("read-write F0", r, {1'b1, 1'b0, 8'h11});
    rd(8'h70, 8'h33, 1'b0);
  endtask

  // Indirect paths, with the bank bit of status set to show it selects nothing.
  task automatic s_indirect();
    wr(8'h04, 8'h25, 1'b0);
    wr(8'h00, 8'h3C, 1'b0);
    rd(8'h25, 8'h3C, 1'b0);
    rd(8'h80, 8'h3C, 1'b0);
    wr(8'h03, 8'h81, 1'b0);
    wr(8'h75, 8'h99, 1'b0);
    wr(8'h04, 8'hF5, 1'b0);
    rd(8'h00, 8'h99, 1'b0);
    wr(8'h04, 8'h75, 1'b0);
    rd(8'h80, 8'h99, 1'b0);
    wr(8'h04, 8'h83, 1'b0);
    rd(8'h00, 8'h81, 1'b0);
    wr(8'h04, 8'h04, 1'b0);
    rd(8'h00, 8'h04, 1'b0);
    wr(8'h80, 8'h2A, 1'b0);
    check("pointer", {2'b00, indirect_pointer}, {2'b00, 8'h2A});
  endtask

  // Pointer aimed at the port in either bank: reads zero, writes land nowhere.
  task automatic s_self();
    for (int b = 0; b < 2; b++)
    begin
      wr(8'h04, {b[0], 7'h00}, 1'b0);
      rd({~b[0], 7'h00}, 8'h00, 1'b1);
      wr({b[0], 7'h00}, 8'h55, 1'b1);
      rd(8'h84, {b[0], 7'h00}, 1'b0);
      check("status", {2'b00, core_status}, {2'b00, 8'h81});
    end
  endtask

  initial
  begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    s_regs();
    s_gaps();
    s_indirect();
    s_self();
    conclude();
  end

  // Guard against a hang: running out counts as a mismatch.
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire

// ==== bench/core_model.sv ====
// Model of the core datapath that issues file accesses to the decoder.
// Assumes the decoder answers exactly one edge after taking a request.
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input  wire logic                 clk,
  output var  dmem_pkg::file_req_t  file_req,
  input  wire dmem_pkg::file_resp_t file_resp
);
  initial file_req = '0;

  // One access: drive just after an edge, hold through the taking edge, take the
  // answer after it, then idle with inverted operands so stale values never help.
  task automatic access(input logic rd, input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output dmem_pkg::file_resp_t r);
    @(posedge clk);
    #1;
    file_req = '{rd: rd, wr: wr, bank: a[7], addr: a[6:0], wdata: d};
    @(posedge clk);
    #1;
    r = file_resp;
    file_req = '{rd: 1'b0, wr: 1'b0, bank: ~a[7], addr: ~a[6:0], wdata: ~d};
  endtask
endmodule
`default_nettype wire

// ==== bench/dmem_checker_asserts.sv ====
// Port checker for the banked data-memory decoder.
// Assumes one clk domain, synchronous active-high rst, one-cycle registered answers.
`timescale 1ns/1ps
`default_nettype none

module dmem_checker (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire dmem_pkg::file_req_t  file_req,
  input wire dmem_pkg::file_resp_t file_resp,
  input wire logic [7:0]           indirect_pointer,
  input wire logic [7:0]           core_status
);
  // ----------------------------------------------------------------
  // Relations between request and answer
  // ----------------------------------------------------------------
  // One domain, so clock and reset are given once for every property.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Operand naming the indirect port in either bank.
  wire ind_sel = (file_req.addr == 7'h00);
  wire self_ptr = (indirect_pointer[6:0] == 7'h00);

  gap_zero_a: assert property (
    file_req.rd && !file_req.bank && file_req.addr == 7'h07 |=> file_resp.valid
    && file_resp.hit_none && file_resp.data == 8'h00) else $error("gap read not zero");
  bank1_gap_a: assert property (
    file_req.rd && file_req.bank && file_req.addr inside {[7'h20:7'h6F]}
    |=> file_resp.hit_none && file_resp.data == 8'h00) else $error("bank 1 hole not zero");
  self_read_a: assert property (
    file_req.rd && ind_sel && self_ptr |=> file_resp.valid && file_resp.hit_none
    && file_resp.data == 8'h00) else $error("port read through itself not zero");
  self_write_a: assert property (
    file_req.wr && ind_sel && self_ptr |=> file_resp.hit_none
    && $stable(indirect_pointer) && $stable(core_status)) else $error("self write stored");
  ptr_write_a: assert property (
    file_req.wr && file_req.addr == 7'h04 |=> indirect_pointer == $past(file_req.wdata))
    else $error("pointer write lost");
  status_write_a: assert property (
    file_req.wr && file_req.addr == 7'h03 |=> core_status == $past(file_req.wdata))
    else $error("status write lost");
  ind_write_a: assert property (
    file_req.wr && ind_sel && indirect_pointer == 8'h04
    |=> indirect_pointer == $past(file_req.wdata)) else $error("indirect write missed");
  ind_read_a: assert property (
    file_req.rd && ind_sel && indirect_pointer == 8'h04 |=> file_resp.valid
    && file_resp.data == $past(indirect_pointer)) else $error("indirect read wrong");
  ind_bank_a: assert property (
    file_req.rd && ind_sel && indirect_pointer == 8'h83
    |=> file_resp.data == $past(core_status)) else $error("status via pointer wrong");

  cover_ind_wr: cover property (file_req.wr && ind_sel);
  cover_bank1: cover property (file_req.rd && file_req.bank);
  cover_drop: cover property (file_resp.hit_none);
endmodule

bind banked_data_memory_indirect_addr dmem_checker u_checker (
  .clk(clk), .rst(rst), .file_req(file_req), .file_resp(file_resp),
  .indirect_pointer(indirect_pointer), .core_status(core_status));
`default_nettype wire

// ==== logic/banked_data_memory_indirect_addr.sv ====
// Two-bank data-memory decoder with indirect addressing for the core.
// Assumes the core presents one file request per clock, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module banked_data_memory_indirect_addr (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire dmem_pkg::file_req_t  file_req,
  output var  dmem_pkg::file_resp_t file_resp,
  output logic [7:0]                indirect_pointer,
  output logic [7:0]                core_status
);

  // ------------------------------------------------------------------
  // Slot decode
  // ------------------------------------------------------------------
  // Maps an 8-bit file address to a register slot. Registers that sit in
  // both banks decode to one slot, so both views share one storage.
  function automatic logic [4:0] sfr_slot(input logic [7:0] a);
    logic [4:0] s;
    s = dmem_pkg::SLOT_NONE;
    unique case (a)
      dmem_pkg::ADDR_TIMER_COUNT:   s = dmem_pkg::SLOT_TIMER;
      dmem_pkg::ADDR_PCL,
      dmem_pkg::ADDR_PCL1:          s = dmem_pkg::SLOT_PCL;     // [RULE_08]
      dmem_pkg::ADDR_CORE_STATUS,
      dmem_pkg::ADDR_CORE_STATUS1:  s = dmem_pkg::SLOT_STATUS;  // [RULE_08]
      dmem_pkg::ADDR_IND_POINTER,
      dmem_pkg::ADDR_IND_POINTER1:  s = dmem_pkg::SLOT_POINTER; // [RULE_08]
      dmem_pkg::ADDR_PORT_A_DATA:   s = dmem_pkg::SLOT_PORT_A;
      dmem_pkg::ADDR_PORT_B_DATA:   s = dmem_pkg::SLOT_PORT_B;
      dmem_pkg::ADDR_PROGRAM_COUNTER_HIGH_LATCH,
      dmem_pkg::ADDR_PCLATH1:       s = dmem_pkg::SLOT_PROGRAM_COUNTER_HIGH_LATCH;  // [RULE_08]
      dmem_pkg::ADDR_INT_CONTROL,
      dmem_pkg::ADDR_INT_CONTROL1:  s = dmem_pkg::SLOT_INTCTL;  // [RULE_08]
      dmem_pkg::ADDR_PERIPH_FLAGS:  s = dmem_pkg::SLOT_PFLAGS;
      dmem_pkg::ADDR_COMPARATOR:    s = dmem_pkg::SLOT_COMPARATOR;
      dmem_pkg::ADDR_OPTION_CONFIG: s = dmem_pkg::SLOT_OPTION;
      dmem_pkg::ADDR_PORT_A_DIR:    s = dmem_pkg::SLOT_DIR_A;
      dmem_pkg::ADDR_PORT_B_DIR:    s = dmem_pkg::SLOT_DIR_B;
      dmem_pkg::ADDR_PERIPH_ENABLE: s = dmem_pkg::SLOT_PENABLE;
      dmem_pkg::ADDR_POWER_CONTROL: s = dmem_pkg::SLOT_POWER;
      dmem_pkg::ADDR_EEPROM_SERIAL: s = dmem_pkg::SLOT_EEPROM;
      dmem_pkg::ADDR_VREF_CONTROL:  s = dmem_pkg::SLOT_VREF;
      // The indirect port and the gaps have no slot at all.
      default:                      s = dmem_pkg::SLOT_NONE;    // [RULE_01] [RULE_02]
    endcase
    return s;
  endfunction

  // ------------------------------------------------------------------
  // Storage declarations
  // ------------------------------------------------------------------
  logic [7:0] sfr_q [dmem_pkg::NUM_SLOTS];
  logic [7:0] ram_rdata;

  // ------------------------------------------------------------------
  // Address formation
  // ------------------------------------------------------------------
  wire logic [7:0] direct_addr;
  wire logic       direct_is_port;
  wire logic [8:0] eff_addr;
  wire logic [7:0] sel_addr;
  wire logic       bank_bit;

  // The direct address is the bank select above the 7-bit operand.
  assign direct_addr    = {file_req.bank, file_req.addr};
  assign direct_is_port = (file_req.addr == dmem_pkg::PORT_LOW7);
  assign bank_bit       = sfr_q[dmem_pkg::SLOT_STATUS][dmem_pkg::IND_BANK_BIT];

  // Naming the port in either bank redirects the access through the
  // pointer; the bank bit rides above it to give a 9-bit address.
  assign eff_addr = direct_is_port ? {bank_bit, sfr_q[dmem_pkg::SLOT_POINTER]} // [RULE_03]
                                   : {1'h0, direct_addr};                      // [RULE_06]

  // Only the low eight bits select a location; bit 8 is dropped on
  // purpose, so the bank bit never moves an indirect access.
  assign sel_addr = eff_addr[7:0]; // [RULE_07]

  // ------------------------------------------------------------------
  // Target classification
  // ------------------------------------------------------------------
  wire logic                       target_is_port;
  wire logic                       in_common;
  wire logic                       in_gpr_bank0;
  wire logic                       is_gpr;
  wire logic [4:0]                 slot;
  wire logic                       is_sfr;
  wire logic                       hit_none;
  wire logic [dmem_pkg::GPR_AW-1:0] gpr_index;

  // A direct access can only hit the port through redirection, so this
  // test alone catches a pointer that aims at the port itself.
  assign target_is_port = (sel_addr[6:0] == dmem_pkg::PORT_LOW7); // [RULE_04] [RULE_05]

  // The top sixteen bytes of either bank reach the same RAM cells.
  assign in_common    = (sel_addr[6:0] >= dmem_pkg::COMMON_LOW7); // [RULE_08]
  assign in_gpr_bank0 = !sel_addr[7] && (sel_addr[6:0] >= dmem_pkg::GPR_LOW7);
  assign is_gpr       = in_common || in_gpr_bank0;

  // Bank 1 from A0h up to EFh has no RAM and falls through to zero.
  assign gpr_index = sel_addr[6:0] - dmem_pkg::GPR_LOW7;
  assign slot      = sfr_slot(sel_addr);
  assign is_sfr    = !is_gpr && (slot != dmem_pkg::SLOT_NONE);
  assign hit_none  = !is_gpr && !is_sfr; // [RULE_01]

  // ------------------------------------------------------------------
  // Write strobes
  // ------------------------------------------------------------------
  wire logic wr_gpr;
  wire logic wr_sfr;

  // A write that lands on the port or a gap is dropped here; the core
  // may still update its own flags from the same instruction.
  assign wr_gpr = file_req.wr && is_gpr && !target_is_port; // [RULE_05]
  assign wr_sfr = file_req.wr && is_sfr && !target_is_port; // [RULE_05] [RULE_01]

  // ------------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------------
  wire logic [7:0] sfr_rdata;
  wire logic [7:0] rd_value;

  // Slot is range-checked before the array is read to keep X out.
  assign sfr_rdata = is_sfr ? sfr_q[slot] : 8'h00;

  // Priority: port self-reference first, then RAM, then registers.
  assign rd_value = target_is_port ? 8'h00       // [RULE_04]
                  : is_gpr         ? ram_rdata
                  : is_sfr         ? sfr_rdata
                  :                  8'h00;      // [RULE_01]

  // ------------------------------------------------------------------
  // General-purpose RAM
  // ------------------------------------------------------------------
  gpr_ram u_gpr_ram (
    .clk     (clk),
    .wr_en   (wr_gpr),
    .addr    (gpr_index),
    .wr_data (file_req.wdata),
    .rd_data (ram_rdata)
  );

  // ------------------------------------------------------------------
  // Special-function register storage
  // ------------------------------------------------------------------
  // Peripheral side effects live elsewhere; this only keeps the values
  // the core writes so the pointer steers the decode; the status bank bit selects nothing.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < dmem_pkg::NUM_SLOTS; i++)
      begin
        sfr_q[i] <= dmem_pkg::SFR_RESET;
      end
    end
    else if (wr_sfr)
    begin
      sfr_q[slot] <= file_req.wdata;
    end
  end

  // ------------------------------------------------------------------
  // Response register
  // ------------------------------------------------------------------
  // Read data is registered one cycle after the strobe. Data is forced
  // to zero when no read was asked so the bus never shows stale bytes.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      file_resp <= '0;
    end
    else
    begin
      file_resp.valid    <= file_req.rd;
      file_resp.hit_none <= (file_req.rd || file_req.wr) && (hit_none || target_is_port);
      file_resp.data     <= file_req.rd ? rd_value : 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Views for the core
  // ------------------------------------------------------------------
  // The core needs the status byte for its flag logic and bank select.
  assign indirect_pointer = sfr_q[dmem_pkg::SLOT_POINTER];
  assign core_status      = sfr_q[dmem_pkg::SLOT_STATUS];

endmodule

`default_nettype wire

// ==== logic/dmem_pkg.sv ====
// Constants, layouts and carrier types for the banked data-memory decoder.
// Assumes one core clock; every file access is a single-cycle request.
//
// How it works
// RULE_01: Unimplemented locations read zero, store nothing.
// RULE_02: Indirect data port has no storage behind it.
// RULE_03: Naming the port accesses the pointer's address.
// RULE_04: Pointer at the port itself reads 00h.
// RULE_05: Pointer at the port itself: writes change nothing.
// RULE_06: Effective address is bank bit above pointer.
// RULE_07: Indirect bank bit is ignored for selection.
// RULE_08: F0h-FFh mirror 70h-7Fh; shared registers unified.
`default_nettype none

package dmem_pkg;

  // ------------------------------------------------------------------
  // File map, bank 0
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_INDIRECT_PORT  = 8'h00;
  localparam logic [7:0] ADDR_TIMER_COUNT    = 8'h01;
  localparam logic [7:0] ADDR_PCL            = 8'h02;
  localparam logic [7:0] ADDR_CORE_STATUS    = 8'h03;
  localparam logic [7:0] ADDR_IND_POINTER    = 8'h04;
  localparam logic [7:0] ADDR_PORT_A_DATA    = 8'h05;
  localparam logic [7:0] ADDR_PORT_B_DATA    = 8'h06;
  localparam logic [7:0] ADDR_PROGRAM_COUNTER_HIGH_LATCH         = 8'h0A;
  localparam logic [7:0] ADDR_INT_CONTROL    = 8'h0B;
  localparam logic [7:0] ADDR_PERIPH_FLAGS   = 8'h0C;
  localparam logic [7:0] ADDR_COMPARATOR     = 8'h1F;

  // ------------------------------------------------------------------
  // File map, bank 1
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_INDIRECT_PORT1 = 8'h80;
  localparam logic [7:0] ADDR_OPTION_CONFIG  = 8'h81;
  localparam logic [7:0] ADDR_PCL1           = 8'h82;
  localparam logic [7:0] ADDR_CORE_STATUS1   = 8'h83;
  localparam logic [7:0] ADDR_IND_POINTER1   = 8'h84;
  localparam logic [7:0] ADDR_PORT_A_DIR     = 8'h85;
  localparam logic [7:0] ADDR_PORT_B_DIR     = 8'h86;
  localparam logic [7:0] ADDR_PCLATH1        = 8'h8A;
  localparam logic [7:0] ADDR_INT_CONTROL1   = 8'h8B;
  localparam logic [7:0] ADDR_PERIPH_ENABLE  = 8'h8C;
  localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h8E;
  localparam logic [7:0] ADDR_EEPROM_SERIAL  = 8'h90;
  localparam logic [7:0] ADDR_VREF_CONTROL   = 8'h9F;

  // ------------------------------------------------------------------
  // General-purpose RAM windows, as 7-bit in-bank offsets
  // ------------------------------------------------------------------
  localparam logic [6:0] PORT_LOW7   = 7'h00;
  localparam logic [6:0] GPR_LOW7    = 7'h20;
  localparam logic [6:0] COMMON_LOW7 = 7'h70;
  localparam int         GPR_DEPTH   = 96;
  localparam int         GPR_AW      = 7;

  // Position of the indirect bank bit inside the core status register.
  localparam int         IND_BANK_BIT = 7;

  // Value every special-function register takes at reset.
  localparam logic [7:0] SFR_RESET = 8'h00;

  // ------------------------------------------------------------------
  // Storage slots of the special-function registers
  // ------------------------------------------------------------------
  localparam int         NUM_SLOTS       = 17;
  localparam logic [4:0] SLOT_TIMER      = 5'h00;
  localparam logic [4:0] SLOT_PCL        = 5'h01;
  localparam logic [4:0] SLOT_STATUS     = 5'h02;
  localparam logic [4:0] SLOT_POINTER    = 5'h03;
  localparam logic [4:0] SLOT_PORT_A     = 5'h04;
  localparam logic [4:0] SLOT_PORT_B     = 5'h05;
  localparam logic [4:0] SLOT_PROGRAM_COUNTER_HIGH_LATCH     = 5'h06;
  localparam logic [4:0] SLOT_INTCTL     = 5'h07;
  localparam logic [4:0] SLOT_PFLAGS     = 5'h08;
  localparam logic [4:0] SLOT_COMPARATOR = 5'h09;
  localparam logic [4:0] SLOT_OPTION     = 5'h0A;
  localparam logic [4:0] SLOT_DIR_A      = 5'h0B;
  localparam logic [4:0] SLOT_DIR_B      = 5'h0C;
  localparam logic [4:0] SLOT_PENABLE    = 5'h0D;
  localparam logic [4:0] SLOT_POWER      = 5'h0E;
  localparam logic [4:0] SLOT_EEPROM     = 5'h0F;
  localparam logic [4:0] SLOT_VREF       = 5'h10;
  localparam logic [4:0] SLOT_NONE       = 5'h1F;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       bank;
    logic [6:0] addr;
    logic [7:0] wdata;
  } file_req_t;

  typedef struct packed {
    logic       valid;
    logic       hit_none;
    logic [7:0] data;
  } file_resp_t;

endpackage

`default_nettype wire

// ==== logic/gpr_ram.sv ====
// General-purpose RAM array of the data memory.
// Assumes a single address for read and write; read is combinational.
`timescale 1ns/1ps
`default_nettype none

module gpr_ram (
  input  wire logic                       clk,
  input  wire logic                       wr_en,
  input  wire logic [dmem_pkg::GPR_AW-1:0] addr,
  input  wire logic [7:0]                 wr_data,
  output logic      [7:0]                 rd_data
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  // Contents are not reset; software must initialise the RAM itself.
  logic [7:0] mem [dmem_pkg::GPR_DEPTH];

  // Writes land at the clock edge; a read in the same cycle sees old data.
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[addr] <= wr_data;
    end
  end

  // Read path stays combinational so the decoder can register it once.
  assign rd_data = mem[addr];

endmodule

`default_nettype wire
